/* rtl/power_mode_sequencer.sv */
// Power-mode and reset sequencer with an Avalon-MM register slave.
// Assumes pins arrive asynchronously; save and detach acks come from core_clk logic.
`timescale 1ns/1ns
`default_nettype none
module power_mode_sequencer (
    input wire logic core_clk, // 10 MHz core clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic ce, // Clock enable, freezes all state when low
    input wire logic [pwr_seq_pkg::ADDR_W-1:0] address, // Byte address
    input wire logic read, // Avalon read
    input wire logic write, // Avalon write
    input wire logic [31:0] writedata, // Avalon write data
    output logic [31:0] readdata, // Avalon read data
    output logic waitrequest, // Avalon wait request
    input wire pwr_seq_pkg::pin_s pins_async, // Pins and wake sources
    input wire logic save_done, // Settings stored in non-volatile memory
    input wire logic detach_done, // Network detach finished
    output var pwr_seq_pkg::pwr_out_s pwr_out // Power controls and mode
);
    import pwr_seq_pkg::*;

    pin_s pins;
    state_e state_reg;
    state_e state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] wake_en_reg;
    logic [7:0] cause_reg;
    logic [7:0] cause_set;
    logic [GPIO_W-1:0] latch_reg;
    logic [31:0] rd_mux;
    logic wr_en;
    logic cmd_standby;
    logic cmd_sleep;
    logic cmd_off;
    logic fault_bo;
    logic fault_hw;
    logic fault_temp;
    logic fault_any;
    logic sel_pin;
    logic gpio_change;
    logic wake_sleep;
    logic wake_standby;
    logic go_sleep;
    logic reboot_over;

    wake_sync #(
        .W($bits(pin_s)),
        .INIT(PIN_INIT)
    ) u_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .ce(ce),
        .d(pins_async),
        .q(pins)
    );

    // Bus: one wait cycle, then the access completes
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            waitrequest <= 1'b1;
        else if (ce)
        begin
            if ((read || write) && !waitrequest)
                waitrequest <= 1'b1;
            else if (read || write)
                waitrequest <= 1'b0;
        end
    end

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (address)
            OFF_CTRL: rd_mux[7:0] = ctrl_reg;
            OFF_WAKE_EN: rd_mux[7:0] = wake_en_reg;
            OFF_STATUS:
            begin
                rd_mux[5:0] = state_reg;
                rd_mux[STATUS_BUCK] = pwr_out.buck_sel;
            end
            OFF_CAUSE: rd_mux[7:0] = cause_reg;
            OFF_LATCH: rd_mux[GPIO_W-1:0] = latch_reg;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            readdata <= 32'h0000_0000;
        else if (ce && read && waitrequest)
            readdata <= rd_mux;
    end

    assign wr_en = ce && write && !waitrequest;
    assign cmd_standby = wr_en && address == OFF_CMD && writedata[CMD_STANDBY];
    assign cmd_sleep = wr_en && address == OFF_CMD && writedata[CMD_SLEEP];
    assign cmd_off = wr_en && address == OFF_CMD && writedata[CMD_POWER_OFF];

    assign fault_bo = !pins.supply_ok;
    assign fault_hw = !pins.reset_n;
    assign fault_temp = ctrl_reg[CTRL_TEMP_EN] && pins.temp_bad;
    assign fault_any = fault_bo || fault_hw || fault_temp;

    assign sel_pin = pins.gpio[ctrl_reg[CTRL_SEL_MSB:CTRL_SEL_LSB]];
    assign gpio_change = ctrl_reg[CTRL_LATCH_EN] && wake_en_reg[WK_GPIO]
        && (pins.gpio != latch_reg);
    assign wake_sleep = (wake_en_reg[WK_DIG] && pins.dig_event)
        || (wake_en_reg[WK_COMP] && pins.comp_event)
        || (wake_en_reg[WK_NFC] && pins.nfc_field)
        || (wake_en_reg[WK_VBUS] && pins.vbus_present)
        || gpio_change
        || (ctrl_reg[CTRL_GPIO_CTL_EN] && sel_pin);
    assign wake_standby = wake_sleep
        || (wake_en_reg[WK_RTC] && pins.rtc_event)
        || (wake_en_reg[WK_RADIO] && pins.radio_event);
    assign go_sleep = cmd_sleep || (ctrl_reg[CTRL_GPIO_CTL_EN] && !sel_pin);
    assign reboot_over = cnt_reg >= CNT_W'(REBOOT_CYC - 1);

    always_comb
    begin
        state_next = state_reg;
        if (fault_any)
            state_next = ST_REBOOT;
        else
        begin
            case (state_reg)
                ST_ACTIVE:
                begin
                    if (cmd_off)
                        state_next = ST_SAVE;
                    else if (go_sleep)
                        state_next = ST_SLEEP;
                    else if (cmd_standby)
                        state_next = ST_STANDBY;
                end
                ST_STANDBY:
                    if (wake_standby)
                        state_next = ST_ACTIVE;
                // only an event leaves, via reboot
                ST_SLEEP:
                    if (wake_sleep)
                        state_next = ST_REBOOT;
                ST_SAVE:
                    if (save_done)
                        state_next = ST_DETACH;
                ST_DETACH:
                    if (detach_done)
                        state_next = ST_REBOOT;
                // reboot ends after REBOOT_CYC cycles with supply and pin good
                ST_REBOOT:
                    if (reboot_over)
                        state_next = ST_ACTIVE;
                default: state_next = ST_REBOOT;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            state_reg <= ST_ACTIVE;
        else if (ce)
            state_reg <= state_next;
    end

    // Counter restarts while a fault holds the reboot
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            cnt_reg <= '0;
        else if (ce)
        begin
            if (state_reg != ST_REBOOT || fault_any)
                cnt_reg <= '0;
            else if (!reboot_over)
                cnt_reg <= cnt_reg + CNT_W'(1);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            ctrl_reg <= CTRL_RESET;
            wake_en_reg <= WAKE_EN_RESET;
        end
        else if (ce)
        begin
            if (state_reg == ST_REBOOT)
            begin
                ctrl_reg <= CTRL_RESET;
                wake_en_reg <= WAKE_EN_RESET;
            end
            else if (wr_en && address == OFF_CTRL)
                ctrl_reg <= writedata[7:0];
            else if (wr_en && address == OFF_WAKE_EN)
                wake_en_reg <= writedata[7:0];
        end
    end

    // Cause survives internal reboots so software can read why
    always_comb
    begin
        cause_set = 8'h00;
        cause_set[CA_BROWNOUT] = fault_bo;
        cause_set[CA_HW_RESET] = fault_hw;
        cause_set[CA_TEMP] = fault_temp;
        cause_set[CA_SW_OFF] = state_reg == ST_DETACH && detach_done;
        cause_set[CA_SLEEP_WAKE] = state_reg == ST_SLEEP && wake_sleep;
    end

    // Set wins over a write-one clear
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            cause_reg <= CAUSE_RESET;
        else if (ce)
        begin
            if (wr_en && address == OFF_CAUSE)
                cause_reg <= (cause_reg & ~writedata[7:0]) | cause_set;
            else
                cause_reg <= cause_reg | cause_set;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            latch_reg <= '0;
        else if (ce && state_reg != ST_SLEEP && state_next == ST_SLEEP)
            latch_reg <= pins.gpio;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            pwr_out <= '0;
            pwr_out.mode[MODE_ACTIVE] <= 1'b1;
            pwr_out.sys_rst_n <= 1'b1;
        end
        else if (ce)
        begin
            pwr_out.mode[MODE_ACTIVE] <= state_next != ST_STANDBY && state_next != ST_SLEEP;
            pwr_out.mode[MODE_STANDBY] <= state_next == ST_STANDBY;
            pwr_out.mode[MODE_SLEEP] <= state_next == ST_SLEEP;
            pwr_out.sys_rst_n <= state_next != ST_REBOOT;
            pwr_out.lf_clk_sel <= state_next == ST_STANDBY;
            // logic off in both saving modes
            pwr_out.logic_off <= state_next == ST_STANDBY || state_next == ST_SLEEP;
            pwr_out.ram_retain <= state_next == ST_STANDBY || state_next == ST_SLEEP;
            // buck only when active and heavily loaded
            pwr_out.buck_sel <= state_next == ST_ACTIVE && pins.heavy_load;
            pwr_out.gpio_hold <= state_next == ST_SLEEP && ctrl_reg[CTRL_LATCH_EN];
            pwr_out.nvm_save_req <= state_next == ST_SAVE;
            pwr_out.net_detach_req <= state_next == ST_DETACH;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    one_mode_a: assert property ($onehot(pwr_out.mode))
        else $error("power mode not one-hot");
    brownout_reboot_a: assert property (ce && fault_bo |=> !pwr_out.sys_rst_n)
        else $error("brown-out did not reset");
    hw_reset_a: assert property (ce && !pins.reset_n |=> state_reg == ST_REBOOT)
        else $error("reset pin ignored");
    temp_gate_a: assert property (ce && pins.temp_bad && ctrl_reg[CTRL_TEMP_EN]
        |=> state_reg == ST_REBOOT)
        else $error("temperature shutdown missed");
    save_order_a: assert property (state_reg == ST_SAVE && ce && !fault_any
        && !save_done |=> pwr_out.nvm_save_req && !pwr_out.net_detach_req)
        else $error("save not before detach");
    standby_clock_a: assert property (state_reg == ST_STANDBY |-> pwr_out.lf_clk_sel
        && pwr_out.ram_retain && pwr_out.sys_rst_n)
        else $error("standby clock wrong");
    sleep_wake_a: assert property (ce && state_reg == ST_SLEEP && wake_sleep
        |=> state_reg == ST_REBOOT ##0 cause_reg[CA_SLEEP_WAKE])
        else $error("sleep wake without reboot");
    reboot_clear_a: assert property (ce && state_reg == ST_REBOOT
        |=> wake_en_reg == WAKE_EN_RESET && ctrl_reg == CTRL_RESET)
        else $error("config kept over reboot");
    buck_light_a: assert property (pwr_out.buck_sel |-> pwr_out.mode[MODE_ACTIVE])
        else $error("buck outside active");
    reboot_len_a: assert property (ce && state_reg != ST_REBOOT
        ##1 state_reg == ST_REBOOT && !fault_any && ce |-> cnt_reg == '0)
        else $error("reboot count not restarted");

    standby_wake_c: cover property (state_reg == ST_STANDBY ##1 state_reg == ST_ACTIVE);
    sleep_wake_c: cover property (state_reg == ST_SLEEP ##1 state_reg == ST_REBOOT);
    power_off_c: cover property (state_reg == ST_DETACH ##1 state_reg == ST_REBOOT);
endmodule // power_mode_sequencer
`default_nettype wire

/* rtl/pwr_seq_pkg.sv */
// Constants, types and register map of the power-mode sequencer.
// Assumes one 10 MHz core clock and an Avalon-MM master on the register bus.
// Behaviour
// - Exactly three power modes: active, standby and sleep; sleep saves most.
// - Power-on or reboot on valid supply rising, and on a module reset.
// - Sleep wakes on digital or analog sensor event, NFC field, or USB supply.
// - Standby additionally wakes on real time counter and radio events.
// - Standby powers down logic but keeps RAM and configuration; no reboot.
// - Retained logic runs from the 32 kHz crystal clock during standby.
// - Sleep stops all functions until an external event arrives.
// - Waking from sleep always reboots; only retained RAM keeps contents.
// - Sleep wake sources: digital pin, low-power comparator, NFC field, USB supply.
// - Optionally latch GPIO inputs on sleep entry; any change wakes.
// - No power-off pin; any GPIO may be chosen to enter or leave sleep.
// - Brown-out of the main supply shuts down without saving settings.
// - Temperature out of range shuts down, only when enabled; off by default.
// - Low on the external reset input resets at once, no save; idles high.
// - Software power-off saves settings, detaches from network, then resets.
// - Linear regulator under light load, buck converter under heavy load; the code selects buck under heavy load in active mode only.
package pwr_seq_pkg;

    localparam int ADDR_W = 5;
    localparam int GPIO_W = 8;
    localparam int CLK_NS = 100;
    localparam int REBOOT_NS = 1000;
    localparam int REBOOT_CYC = (REBOOT_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_WAKE_EN = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_CAUSE = 5'h0C;
    localparam logic [ADDR_W-1:0] OFF_LATCH = 5'h10;
    localparam logic [ADDR_W-1:0] OFF_CMD = 5'h14;

    // Control fields
    localparam int CTRL_TEMP_EN = 0;
    localparam int CTRL_LATCH_EN = 1;
    localparam int CTRL_GPIO_CTL_EN = 2;
    localparam int CTRL_SEL_LSB = 4;
    localparam int CTRL_SEL_MSB = 6;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Wake enable fields
    localparam int WK_DIG = 0;
    localparam int WK_COMP = 1;
    localparam int WK_NFC = 2;
    localparam int WK_VBUS = 3;
    localparam int WK_RTC = 4;
    localparam int WK_RADIO = 5;
    localparam int WK_GPIO = 6;
    localparam logic [7:0] WAKE_EN_RESET = 8'h00;

    // Cause fields, write one to clear
    localparam int CA_BROWNOUT = 0;
    localparam int CA_HW_RESET = 1;
    localparam int CA_TEMP = 2;
    localparam int CA_SW_OFF = 3;
    localparam int CA_SLEEP_WAKE = 4;
    localparam logic [7:0] CAUSE_RESET = 8'h00;

    // Command fields, self-clearing
    localparam int CMD_STANDBY = 0;
    localparam int CMD_SLEEP = 1;
    localparam int CMD_POWER_OFF = 2;

    localparam int STATUS_BUCK = 8;

    typedef enum logic [5:0] {
        ST_ACTIVE = 6'b00_0001,
        ST_STANDBY = 6'b00_0010,
        ST_SLEEP = 6'b00_0100,
        ST_SAVE = 6'b00_1000,
        ST_DETACH = 6'b01_0000,
        ST_REBOOT = 6'b10_0000
    } state_e;

    typedef struct packed {
        logic [GPIO_W-1:0] gpio;
        logic reset_n;
        logic supply_ok;
        logic temp_bad;
        logic heavy_load;
        logic dig_event;
        logic comp_event;
        logic nfc_field;
        logic vbus_present;
        logic rtc_event;
        logic radio_event;
    } pin_s;

    // Reset and supply pins idle high so a reset does not look like a fault
    localparam pin_s PIN_INIT = '{gpio: '0, reset_n: 1'b1, supply_ok: 1'b1, default: 1'b0};

    typedef struct packed {
        logic [2:0] mode;
        logic sys_rst_n;
        logic lf_clk_sel;
        logic logic_off;
        logic ram_retain;
        logic buck_sel;
        logic gpio_hold;
        logic nvm_save_req;
        logic net_detach_req;
    } pwr_out_s;

    localparam int MODE_ACTIVE = 0;
    localparam int MODE_STANDBY = 1;
    localparam int MODE_SLEEP = 2;

endpackage

/* rtl/wake_sync.sv */
// Two-flop synchroniser for a vector of asynchronous inputs.
// Assumes inputs change slowly against the clock; bits are not coherent.
`timescale 1ns/1ns
`default_nettype none
module wake_sync #(
    parameter int W = 8,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic core_clk, // Core clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic ce, // Clock enable
    input wire logic [W-1:0] d, // Asynchronous inputs
    output logic [W-1:0] q // Synchronised outputs
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            meta_reg <= INIT;
            q <= INIT;
        end
        else if (ce)
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule // wake_sync
`default_nettype wire

/* verif/far_side_model.sv */
// Far-side model: wake sources, reset pin driver, storage and detach acks.
// Assumes the bench changes its requests just after core_clk rising edges.
`timescale 1ns/1ns
`default_nettype none
module far_side_model (
    input wire logic core_clk, // Core clock
    input wire logic rst_drive, // Pull the reset pin low
    input wire pwr_seq_pkg::pin_s pin_req, // Requested pin levels
    input wire logic [3:0] delay, // Ack delay in cycles
    input wire logic save_req, // Store request from the block
    input wire logic detach_req, // Detach request from the block
    output var pwr_seq_pkg::pin_s pins, // Pins seen by the block
    output logic save_done, // Store finished
    output logic detach_done // Detach finished
);
    import pwr_seq_pkg::*;
    logic [3:0] save_cnt;
    logic [3:0] det_cnt;
    always_comb
    begin
        pins = pin_req;
        pins.reset_n = !rst_drive;
    end
    always_ff @(posedge core_clk)
    begin
        save_cnt <= save_req ? save_cnt + 4'(save_cnt != delay) : 4'h0;
        det_cnt <= detach_req ? det_cnt + 4'(det_cnt != delay) : 4'h0;
    end
    assign save_done = save_req && save_cnt == delay;
    assign detach_done = detach_req && det_cnt == delay;
endmodule // far_side_model
`default_nettype wire

/* verif/test_power_mode_sequencer.sv */
// Self-checking bench for the power-mode sequencer.
// Assumes the far-side model answers storage and detach requests.
`timescale 1ns/1ns
`default_nettype none
module test_power_mode_sequencer;
    import pwr_seq_pkg::*;
    localparam int O_DET = 0, O_SAVE = 1, O_HOLD = 2, O_BUCK = 3, O_RAM = 4, O_OFF = 5, O_LF = 6;
    localparam int O_RST = 7, S_ACT = 8, S_STB = 9, S_SLP = 10;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [ADDR_W-1:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [31:0] readdata;
    logic waitrequest;
    pin_s pin_req = PIN_INIT;
    pin_s pins;
    logic rst_drive = 1'b0;
    logic [3:0] delay = 4'h0;
    logic save_done;
    logic detach_done;
    pwr_out_s pwr_out;
    int errors = 0;
    int cmp_count = 0;
    int saves = 0;
    int lows = 0;

    always #50 core_clk = ~core_clk;
    // Counts of store requests and reboot cycles, for things that must not happen
    always @(posedge core_clk)
    begin
        saves <= saves + int'(pwr_out.nvm_save_req === 1'b1);
        lows <= lows + int'(pwr_out.sys_rst_n === 1'b0);
    end

    power_mode_sequencer i_dut (.core_clk(core_clk), .rstn(rstn), .ce(1'b1),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .pins_async(pins),
        .save_done(save_done), .detach_done(detach_done), .pwr_out(pwr_out));
    far_side_model i_far (.core_clk(core_clk), .rst_drive(rst_drive), .pin_req(pin_req),
        .delay(delay), .save_req(pwr_out.nvm_save_req), .detach_req(pwr_out.net_detach_req),
        .pins(pins), .save_done(save_done), .detach_done(detach_done));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge core_clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        // Only the watchdog ends a stuck access
        @(posedge core_clk);
        while (waitrequest !== 1'b0)
            @(posedge core_clk);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        check(q, exp);
    endtask

    // Bounded wait for one power output bit, then compare it
    task automatic wt(input int b, input logic v);
        int n;
        n = 0;
        while (pwr_out[b] !== v && n < 100)
        begin
            @(posedge core_clk);
            n++;
        end
        check(pwr_out[b], v);
    endtask

    task automatic reboot(input logic [31:0] cause);
        wt(O_RST, 1'b1);
        wt(S_ACT, 1'b1);
        rdc(OFF_CTRL, 32'h0000_0000);
        rdc(OFF_WAKE_EN, 32'h0000_0000);
        rdc(OFF_CAUSE, cause);
        wr(OFF_CAUSE, 32'h0000_00FF);
    endtask

    task automatic t_reset();
        check(pwr_out.mode, 3'b001);
        check(pwr_out.sys_rst_n, 1'b1);
        check(pwr_out[O_RAM], 1'b0);
        rdc(OFF_STATUS, 32'h0000_0001);
        rdc(OFF_CAUSE, 32'h0000_0000);
        wr(OFF_CTRL, 32'h0000_0001);
        rdc(OFF_CTRL, 32'h0000_0001);
        wr(OFF_CTRL, 32'h0000_0000);
        // Unmapped and misaligned places read zero and swallow writes
        wr(5'h18, 32'h0000_00FF);
        rdc(5'h18, 32'h0000_0000);
        rdc(5'h01, 32'h0000_0000);
        $display("test reset finished");
    endtask

    task automatic t_buck();
        pin_req.heavy_load <= 1'b1;
        wt(O_BUCK, 1'b1);
        rdc(OFF_STATUS, 32'h0000_0101);
        pin_req.heavy_load <= 1'b0;
        wt(O_BUCK, 1'b0);
        $display("test buck finished");
    endtask

    // Radio then counter wakes standby; the source left disabled must not
    task automatic t_standby();
        int l;
        for (int j = 0; j < 2; j++)
        begin
            wr(OFF_WAKE_EN, 32'h0000_0020 >> j);
            wr(OFF_CMD, 32'h0000_0001);
            wt(S_STB, 1'b1);
            check(pwr_out[O_LF], 1'b1);
            check(pwr_out[O_OFF], 1'b1);
            check(pwr_out[O_RAM], 1'b1);
            pin_req[1-j] <= 1'b1;
            repeat (8) @(posedge core_clk);
            check(pwr_out[S_STB], 1'b1);
            pin_req[1-j] <= 1'b0;
            l = lows;
            pin_req[j] <= 1'b1;
            wt(S_ACT, 1'b1);
            pin_req[j] <= 1'b0;
            check(lows, l);
            rdc(OFF_WAKE_EN, 32'h0000_0020 >> j);
        end
        $display("test standby finished");
    endtask

    // Each sleep wake source in turn; counter and radio events must not wake
    task automatic t_sleep();
        for (int k = 0; k < 4; k++)
        begin
            wr(OFF_WAKE_EN, 32'h0000_003F);
            wr(OFF_CMD, 32'h0000_0002);
            wt(S_SLP, 1'b1);
            check(pwr_out[O_OFF], 1'b1);
            check(pwr_out[O_RAM], 1'b1);
            pin_req.rtc_event <= 1'b1;
            pin_req.radio_event <= 1'b1;
            repeat (8) @(posedge core_clk);
            check(pwr_out[S_SLP], 1'b1);
            pin_req[5-k] <= 1'b1;
            wt(O_RST, 1'b0);
            pin_req[5-k] <= 1'b0;
            pin_req.rtc_event <= 1'b0;
            pin_req.radio_event <= 1'b0;
            reboot(32'h0000_0010);
        end
        $display("test sleep finished");
    endtask

    task automatic t_latch();
        pin_req.gpio <= 8'hA5;
        wr(OFF_CTRL, 32'h0000_0002);
        wr(OFF_WAKE_EN, 32'h0000_0040);
        wr(OFF_CMD, 32'h0000_0002);
        wt(S_SLP, 1'b1);
        wt(O_HOLD, 1'b1);
        rdc(OFF_LATCH, 32'h0000_00A5);
        pin_req.gpio <= 8'hA4;
        wt(O_RST, 1'b0);
        reboot(32'h0000_0010);
        $display("test latch finished");
    endtask

    task automatic t_gpio_ctl();
        pin_req.gpio <= 8'h08;
        wr(OFF_CTRL, 32'h0000_0034);
        pin_req.gpio <= 8'h00;
        wt(S_SLP, 1'b1);
        pin_req.gpio <= 8'h08;
        wt(O_RST, 1'b0);
        reboot(32'h0000_0010);
        $display("test gpio control finished");
    endtask

    // Prompt and slow storage answers
    task automatic t_power_off();
        for (int i = 0; i < 2; i++)
        begin
            delay <= 4'(i * 4);
            wr(OFF_CMD, 32'h0000_0004);
            wt(O_SAVE, 1'b1);
            check(pwr_out[O_DET], 1'b0);
            wt(O_DET, 1'b1);
            check(pwr_out[O_SAVE], 1'b0);
            wt(O_RST, 1'b0);
            reboot(32'h0000_0008);
        end
        $display("test power off finished");
    endtask

    task automatic t_fault(input int k);
        int s;
        s = saves;
        case (k)
            0: pin_req.supply_ok <= 1'b0;
            1: rst_drive <= 1'b1;
            default: pin_req.temp_bad <= 1'b1;
        endcase
        wt(O_RST, 1'b0);
        pin_req.supply_ok <= 1'b1;
        pin_req.temp_bad <= 1'b0;
        rst_drive <= 1'b0;
        reboot(32'h0000_0001 << k);
        check(saves, s);
    endtask

    task automatic t_faults();
        int l;
        l = lows;
        pin_req.temp_bad <= 1'b1;
        repeat (20) @(posedge core_clk);
        check(lows, l);
        pin_req.temp_bad <= 1'b0;
        t_fault(0);
        t_fault(1);
        wr(OFF_CTRL, 32'h0000_0001);
        t_fault(2);
        $display("test faults finished");
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_buck();
        t_standby();
        t_sleep();
        t_latch();
        t_gpio_ctl();
        t_power_off();
        t_faults();
        test_done();
    end

    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge core_clk);
        errors++;
        test_done();
    end
endmodule // test_power_mode_sequencer
`default_nettype wire
